// [kgc_block_check.sv]
// Behaviour
// R1 - mode codes 000..011 select CRC-12, CRC-16, LRC-8, LRC-16; 100 undefined
// R2 - code 101 selects CRC-CCITT; 110 and 111 undefined
// R3 - polynomial_select is read/write and cleared by bus_initialize
// R4 - double_byte_enable picks one or two characters per load; cleared by init
// R5 - host sends characters in line order, first one right-justified
// R6 - clear_accumulation zeroes block_check_register and sets done; not stored
// R7 - step with full cycle off does exactly one shift and xor
// R8 - full cycle on: a complete shift cycle follows every data load
// R9 - shift_enable_full_cycle is read/write and cleared by bus_initialize
// R10 - while done is set a data write loads all 16 bits in parallel
// R11 - done is set after the last shift, on clear, and on init
// R12 - while done is clear the data register shifts right
// R13 - done is cleared after the load, before the select drops
// R14 - quotient_bit is data lsb xor accumulation lsb; init clears it
// R15 - bus_initialize clears the whole data register
// R16 - data select with low write strobe loads the 16 data lines
// R17 - after a load further shift pulses shift the data register
// R18 - load or shift chosen by the mode at the data register clock; the code only loads there, shifts come from step or the shift cycle
// R19 - block_check_register is 16 bits, read-only, holds the accumulation
// R20 - eight shifts per load, sixteen in two-character mode
`default_nettype none
module kgc_block_check
    import kgc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic bus_initialize_i,
    input wire logic csr_select_i,
    input wire logic data_reg_select_i,
    input wire logic bcc_select_i,
    input wire logic write_low_strobe_i,
    input wire logic [KGC_DW-1:0] bus_data_i,
    output logic [KGC_DW-1:0] read_data_o,
    output logic ack_o
);
    typedef struct packed {
        logic [1:0] init_sy;
        logic [1:0] csel_sy;
        logic [1:0] dsel_sy;
        logic [1:0] bsel_sy;
        logic [1:0] wlo_sy;
        logic [1:0][KGC_DW-1:0] data_sy;
        logic wr_seen;
        kgc_state_e state;
        logic [2:0] mode;
        logic ddb;
        logic shift_enable_full_cycle;
        logic done;
        logic [KGC_CNT_W-1:0] cnt;
        logic [KGC_DW-1:0] dr;
        logic [KGC_DW-1:0] bcc;
        logic [KGC_DW-1:0] rdata;
        logic ack;
    } kgc_regs_s;

    kgc_regs_s cur_ff;
    kgc_regs_s nxt_ff;

    logic init_s;
    logic wr_s;
    logic csr_wr;
    logic dr_wr;
    logic [KGC_DW-1:0] wdata;
    logic quotient_bit;
    logic [KGC_DW-1:0] csr_view;

    assign init_s = cur_ff.init_sy[1];
    assign wdata = cur_ff.data_sy[1];
    assign wr_s = cur_ff.wlo_sy[1] & ~cur_ff.wr_seen;
    assign csr_wr = wr_s & cur_ff.csel_sy[1];
    assign dr_wr = wr_s & cur_ff.dsel_sy[1];
    assign quotient_bit = cur_ff.dr[0] ^ cur_ff.bcc[0]; // [R14]

    always_comb begin
        csr_view = WORD_ZERO;
        csr_view[CSR_MODE_MSB:CSR_MODE_LSB] = cur_ff.mode; // [R3]
        csr_view[CSR_DDB] = cur_ff.ddb; // [R4]
        csr_view[CSR_SEN] = cur_ff.shift_enable_full_cycle; // [R9]
        csr_view[CSR_DONE] = cur_ff.done;
        csr_view[CSR_QUO] = quotient_bit; // [R14]
    end

    always_comb begin
        nxt_ff = cur_ff;
        // two-stage synchronisers for the asynchronous bus pins
        nxt_ff.init_sy = {cur_ff.init_sy[0], bus_initialize_i};
        nxt_ff.csel_sy = {cur_ff.csel_sy[0], csr_select_i};
        nxt_ff.dsel_sy = {cur_ff.dsel_sy[0], data_reg_select_i};
        nxt_ff.bsel_sy = {cur_ff.bsel_sy[0], bcc_select_i};
        nxt_ff.wlo_sy = {cur_ff.wlo_sy[0], write_low_strobe_i};
        nxt_ff.data_sy = {cur_ff.data_sy[0], bus_data_i};
        nxt_ff.wr_seen = cur_ff.wlo_sy[1];
        nxt_ff.ack = cur_ff.wlo_sy[1] & (cur_ff.csel_sy[1] | cur_ff.dsel_sy[1]
            | cur_ff.bsel_sy[1]) | (~cur_ff.wlo_sy[1] & (cur_ff.csel_sy[1]
            | cur_ff.dsel_sy[1] | cur_ff.bsel_sy[1]));

        // read data for the selected register
        if (cur_ff.csel_sy[1]) begin
            nxt_ff.rdata = csr_view;
        end else if (cur_ff.dsel_sy[1]) begin
            nxt_ff.rdata = cur_ff.dr;
        end else if (cur_ff.bsel_sy[1]) begin
            nxt_ff.rdata = cur_ff.bcc; // [R19]
        end else begin
            nxt_ff.rdata = WORD_ZERO;
        end

        // automatic shift cycle, one shift per clock
        if (cur_ff.state == KGC_SHIFT) begin
            nxt_ff.bcc = kgc_bcc_step(cur_ff.mode, cur_ff.bcc, quotient_bit); // [R1] [R2] [R20]
            nxt_ff.dr = cur_ff.dr >> 1; // [R12] [R17]
            nxt_ff.cnt = cur_ff.cnt - CNT_LAST;
            if (cur_ff.cnt == CNT_LAST) begin
                nxt_ff.done = 1'b1; // [R11]
                nxt_ff.state = KGC_IDLE;
            end
        end

        if (csr_wr) begin
            nxt_ff.mode = wdata[CSR_MODE_MSB:CSR_MODE_LSB]; // [R3]
            nxt_ff.ddb = wdata[CSR_DDB]; // [R4]
            nxt_ff.shift_enable_full_cycle = wdata[CSR_SEN]; // [R9]
            if (wdata[CSR_CLR]) begin
                nxt_ff.bcc = WORD_ZERO; // [R6]
                nxt_ff.done = 1'b1; // [R11]
                nxt_ff.cnt = CNT_ZERO;
                nxt_ff.state = KGC_IDLE;
            end else if (wdata[CSR_STEP] && !cur_ff.shift_enable_full_cycle && !cur_ff.done
                    && cur_ff.state == KGC_IDLE) begin
                nxt_ff.bcc = kgc_bcc_step(cur_ff.mode, cur_ff.bcc, quotient_bit); // [R7]
                nxt_ff.dr = cur_ff.dr >> 1; // [R7] [R12]
                nxt_ff.cnt = cur_ff.cnt - CNT_LAST;
                if (cur_ff.cnt == CNT_LAST) begin
                    nxt_ff.done = 1'b1; // [R11]
                end
            end
        end

        // data register clock: loads only while done is set and no shift cycle runs; otherwise the write is ignored
        if (dr_wr && cur_ff.done && cur_ff.state == KGC_IDLE) begin // [R18]
            nxt_ff.dr = wdata; // [R10] [R16]
            nxt_ff.done = 1'b0; // [R13]
            nxt_ff.cnt = cur_ff.ddb ? SHIFTS_TWO_CHAR : SHIFTS_ONE_CHAR; // [R20]
            nxt_ff.state = cur_ff.shift_enable_full_cycle ? KGC_SHIFT : KGC_IDLE; // [R8]
        end

        if (init_s) begin
            nxt_ff.mode = MODE_RESET; // [R3]
            nxt_ff.ddb = 1'b0; // [R4]
            nxt_ff.shift_enable_full_cycle = 1'b0; // [R9]
            nxt_ff.dr = WORD_ZERO; // [R15]
            nxt_ff.bcc = WORD_ZERO; // [R14]
            nxt_ff.done = 1'b1; // [R11]
            nxt_ff.cnt = CNT_ZERO;
            nxt_ff.state = KGC_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cur_ff <= '0;
            cur_ff.done <= 1'b1;
            cur_ff.state <= KGC_IDLE;
            cur_ff.mode <= MODE_RESET;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign read_data_o = cur_ff.rdata;
    assign ack_o = cur_ff.ack;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_mode_init_zero: assert property (init_s |=> cur_ff.mode == MODE_RESET && !cur_ff.shift_enable_full_cycle) // [R3]
        else $error("mode or sen not cleared by init");

    a_ddb_write: assert property (csr_wr && !init_s |=> cur_ff.ddb == $past(wdata[CSR_DDB])) // [R4]
        else $error("double_byte_enable not written");

    a_sen_write: assert property (csr_wr && !init_s |=> cur_ff.shift_enable_full_cycle == $past(wdata[CSR_SEN])) // [R9]
        else $error("shift_enable_full_cycle not written");

    a_clear_accum: assert property (csr_wr && wdata[CSR_CLR] && !dr_wr // [R6]
            |=> cur_ff.bcc == WORD_ZERO && cur_ff.done)
        else $error("clear did not zero accumulation and set done");

    a_parallel_load: assert property (dr_wr && cur_ff.done && !init_s // [R10]
            && cur_ff.state == KGC_IDLE |=> cur_ff.dr == $past(wdata) && !cur_ff.done)
        else $error("parallel load failed or done stayed set");

    a_step_one_shift: assert property (csr_wr && wdata[CSR_STEP] && !wdata[CSR_CLR] // [R7]
            && !cur_ff.shift_enable_full_cycle && !cur_ff.done && !init_s && cur_ff.state == KGC_IDLE
            |=> cur_ff.dr == ($past(cur_ff.dr) >> 1))
        else $error("step did not shift exactly once");

    a_full_cycle_len: assert property (dr_wr && cur_ff.done && cur_ff.shift_enable_full_cycle && !cur_ff.ddb // [R8]
            && cur_ff.state == KGC_IDLE && !init_s
            |=> (!cur_ff.done && !csr_wr && !init_s)[*8] ##1 cur_ff.done)
        else $error("full cycle did not take eight shifts");

    a_quo_read: assert property (cur_ff.csel_sy[1] // [R14]
            |=> read_data_o[CSR_QUO] == $past(cur_ff.dr[0] ^ cur_ff.bcc[0]))
        else $error("quotient bit read wrong");

    a_init_clears_dr: assert property (init_s |=> cur_ff.dr == WORD_ZERO && cur_ff.done) // [R15]
        else $error("init did not clear data register");

    a_bcc_read: assert property (cur_ff.bsel_sy[1] && !cur_ff.csel_sy[1] && !cur_ff.dsel_sy[1]
            |=> read_data_o == $past(cur_ff.bcc)) // [R19]
        else $error("accumulation read wrong");

    a_done_last_shift: assert property (cur_ff.state == KGC_SHIFT // [R11]
            && cur_ff.cnt == CNT_LAST |=> cur_ff.done && cur_ff.state == KGC_IDLE)
        else $error("done not set after last shift");

    a_shift_right: assert property (cur_ff.state == KGC_SHIFT && !init_s // [R12]
            |=> cur_ff.dr == ($past(cur_ff.dr) >> 1))
        else $error("data register did not shift right");

    a_busy_load_held: assert property (dr_wr && !cur_ff.done && !init_s && !csr_wr // [R10]
            && cur_ff.state == KGC_IDLE |=> $stable(cur_ff.dr))
        else $error("data write taken while done clear");

    a_clr_not_stored: assert property (cur_ff.csel_sy[1] // [R6]
            |=> !read_data_o[CSR_CLR] && !read_data_o[CSR_STEP])
        else $error("write-only bit read back");

    a_ack_on_select: assert property (cur_ff.csel_sy[1] || cur_ff.dsel_sy[1] // [R16]
            || cur_ff.bsel_sy[1] |=> ack_o)
        else $error("ack missing while selected");

    a_ack_off_idle: assert property (!cur_ff.csel_sy[1] && !cur_ff.dsel_sy[1] // [R16]
            && !cur_ff.bsel_sy[1] |=> !ack_o)
        else $error("ack without select");

    a_init_clears_bcc: assert property (init_s // [R14]
            |=> cur_ff.bcc == WORD_ZERO && cur_ff.state == KGC_IDLE)
        else $error("init did not clear accumulation");

    a_quo_after_init: assert property (init_s // [R14]
            |=> !quotient_bit)
        else $error("quotient not cleared by init");

    a_load_count: assert property (dr_wr && cur_ff.done && cur_ff.state == KGC_IDLE // [R20]
            && !init_s && !csr_wr
            |=> cur_ff.cnt == ($past(cur_ff.ddb) ? SHIFTS_TWO_CHAR : SHIFTS_ONE_CHAR))
        else $error("wrong shift count loaded");

    a_load_starts_shift: assert property (dr_wr && cur_ff.done && cur_ff.shift_enable_full_cycle // [R8]
            && cur_ff.state == KGC_IDLE && !init_s && !csr_wr |=> cur_ff.state == KGC_SHIFT)
        else $error("full cycle did not start");

    a_load_step_mode: assert property (dr_wr && cur_ff.done && !cur_ff.shift_enable_full_cycle // [R7]
            && cur_ff.state == KGC_IDLE && !init_s && !csr_wr |=> cur_ff.state == KGC_IDLE)
        else $error("shift cycle started in step mode");

    a_full_cycle_two: assert property (dr_wr && cur_ff.done && cur_ff.shift_enable_full_cycle && cur_ff.ddb // [R20]
            && cur_ff.state == KGC_IDLE && !init_s
            |=> (!cur_ff.done && !csr_wr && !init_s)[*8]
            ##1 (!cur_ff.done && !csr_wr && !init_s)[*8] ##1 cur_ff.done)
        else $error("two-character cycle did not take sixteen shifts");

    a_rdata_idle: assert property (!cur_ff.csel_sy[1] && !cur_ff.dsel_sy[1] // [R19]
            && !cur_ff.bsel_sy[1] |=> read_data_o == WORD_ZERO)
        else $error("read data not zero when unselected");

    a_read_data_reg: assert property (cur_ff.dsel_sy[1] && !cur_ff.csel_sy[1] // [R10]
            |=> read_data_o == $past(cur_ff.dr))
        else $error("data register read wrong");

    a_mode_write: assert property (csr_wr && !init_s // [R3]
            |=> cur_ff.mode == $past(wdata[CSR_MODE_MSB:CSR_MODE_LSB]))
        else $error("polynomial select not written");

    a_init_clears_ddb: assert property (init_s // [R4]
            |=> !cur_ff.ddb)
        else $error("double_byte_enable not cleared by init");

    a_step_bcc_once: assert property (csr_wr && wdata[CSR_STEP] && !wdata[CSR_CLR] // [R7]
            && !cur_ff.shift_enable_full_cycle && !cur_ff.done && !init_s && cur_ff.state == KGC_IDLE
            |=> cur_ff.bcc == kgc_bcc_step($past(cur_ff.mode), $past(cur_ff.bcc), $past(quotient_bit)))
        else $error("step did not update accumulation once");

    a_clear_idle: assert property (csr_wr && wdata[CSR_CLR] && !dr_wr // [R6]
            |=> cur_ff.state == KGC_IDLE && cur_ff.cnt == CNT_ZERO)
        else $error("clear left a shift cycle running");

    a_csr_read_flags: assert property (cur_ff.csel_sy[1] // [R9]
            |=> read_data_o[CSR_SEN] == $past(cur_ff.shift_enable_full_cycle)
            && read_data_o[CSR_DONE] == $past(cur_ff.done))
        else $error("enable or done read wrong");

    a_csr_read_mode: assert property (cur_ff.csel_sy[1] // [R3]
            |=> read_data_o[CSR_MODE_MSB:CSR_MODE_LSB] == $past(cur_ff.mode)
            && read_data_o[CSR_DDB] == $past(cur_ff.ddb))
        else $error("mode or double_byte_enable read wrong");

    a_csr_upper_zero: assert property (cur_ff.csel_sy[1] // [R6]
            |=> read_data_o[KGC_DW-1:CSR_QUO+1] == '0)
        else $error("unused status bits not zero");

    a_shift_counts: assert property (cur_ff.state == KGC_SHIFT && !init_s // [R20]
            && !(csr_wr && wdata[CSR_CLR]) |=> cur_ff.cnt == $past(cur_ff.cnt) - CNT_LAST)
        else $error("shift counter did not count down");

    a_idle_holds_dr: assert property (cur_ff.state == KGC_IDLE && !dr_wr // [R18]
            && !csr_wr && !init_s |=> $stable(cur_ff.dr))
        else $error("data register moved without a clock");

    a_idle_holds_bcc: assert property (cur_ff.state == KGC_IDLE && !csr_wr // [R19]
            && !init_s |=> $stable(cur_ff.bcc))
        else $error("accumulation moved without a shift");
endmodule : kgc_block_check
`default_nettype wire

// [kgc_block_check_tb.sv]
`default_nettype none
module kgc_block_check_tb
    import kgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, rst_i, bus_initialize_i;
    wire logic csel, dsel, bsel, strobe, ack, hung;
    wire logic [15:0] wdata, rdata;
    int fail_count = 0;
    int comparisons = 0;
    logic [2:0] modes [5] = '{MODE_CRC12, MODE_CRC16, MODE_LRC8, MODE_LRC16, MODE_CCITT};

    kgc_block_check kgc_block_check_i (.clock_i(clock_i), .rst_i(rst_i),
        .bus_initialize_i(bus_initialize_i), .csr_select_i(csel), .data_reg_select_i(dsel),
        .bcc_select_i(bsel), .write_low_strobe_i(strobe), .bus_data_i(wdata),
        .read_data_o(rdata), .ack_o(ack));
    kgc_host_model kgc_host_model_i (.clock_i(clock_i), .ack_i(ack), .read_data_i(rdata),
        .csr_select_o(csel), .data_reg_select_o(dsel), .bcc_select_o(bsel),
        .write_low_strobe_o(strobe), .bus_data_o(wdata), .timed_out_o(hung));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic complete_run;
        if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    always @(posedge hung) begin
        fail_count++;
        complete_run();
    end

    // expected accumulation after n shifts
    function automatic logic [15:0] acc(input logic [2:0] m, input logic [15:0] b,
            input logic [15:0] d, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            q = b[0] ^ d[0];
            d = d >> 1;
            case (m)
                MODE_CRC12: b = (b >> 1) ^ ({16{q}} & POLY_CRC12);
                MODE_CRC16: b = (b >> 1) ^ ({16{q}} & POLY_CRC16);
                MODE_CCITT: b = (b >> 1) ^ ({16{q}} & POLY_CCITT);
                MODE_LRC8: b = {8'h00, q, b[7:1]};
                default: b = {q, b[15:1]};
            endcase
        end
        return b;
    endfunction : acc

    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        logic [15:0] q;
        kgc_host_model_i.rw(s, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [1:0] s, output logic [15:0] q);
        kgc_host_model_i.rw(s, 1'b0, 16'h0000, q);
    endtask : rd

    task automatic wait_done;
        logic [15:0] q;
        int k;
        for (k = 0; k < 10; k++) begin
            rd(2'h0, q);
            if (q[CSR_DONE] === 1'b1) break;
        end
        if (k == 10) begin
            fail_count++;
            complete_run();
        end
    endtask : wait_done

    task automatic t_reset;
        logic [15:0] q;
        rd(2'h0, q);
        check("csr", q, 16'h0080);
        wr(2'h2, 16'h1234);
        rd(2'h2, q);
        check("bcc", q, 16'h0000);
    endtask : t_reset

    task automatic t_modes;
        logic [15:0] q, e;
        foreach (modes[i]) begin
            wr(2'h0, 16'h0050 | {13'h0000, modes[i]});
            wr(2'h1, 16'h00a5);
            wait_done();
            e = acc(modes[i], 16'h0000, 16'h00a5, 8);
            rd(2'h2, q);
            check("bcc", q, e);
            rd(2'h0, q);
            check("csr", q, {7'h00, e[0], 5'h18, modes[i]});
        end
        wr(2'h0, 16'h0059);
        wr(2'h1, 16'h3412);
        wait_done();
        rd(2'h2, q);
        check("bcc", q, acc(MODE_CRC16, 16'h0000, 16'h3412, 16));
    endtask : t_modes

    task automatic t_step;
        logic [15:0] q;
        wr(2'h0, 16'h0013);
        wr(2'h1, 16'h00a5);
        wr(2'h1, 16'hffff);
        rd(2'h1, q);
        check("data", q, 16'h00a5);
        rd(2'h0, q);
        check("csr", q, 16'h0103);
        wr(2'h0, 16'h0023);
        rd(2'h2, q);
        check("bcc", q, acc(MODE_LRC16, 16'h0000, 16'h00a5, 1));
        rd(2'h1, q);
        check("data", q & 16'h7fff, 16'h0052);
        wr(2'h0, 16'h0013);
        rd(2'h2, q);
        check("bcc", q, 16'h0000);
        rd(2'h0, q);
        check("csr", q, 16'h0083);
    endtask : t_step

    task automatic t_init;
        logic [15:0] q;
        wr(2'h1, 16'h5a5a);
        @(posedge clock_i);
        bus_initialize_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        bus_initialize_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rd(2'h0, q);
        check("csr", q, 16'h0080);
        rd(2'h1, q);
        check("data", q, 16'h0000);
    endtask : t_init

    initial begin
        rst_i = 1'b1;
        bus_initialize_i = 1'b0;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        t_reset();
        t_modes();
        t_step();
        t_init();
        complete_run();
    end
endmodule : kgc_block_check_tb
`default_nettype wire

// [kgc_host_model.sv]
`default_nettype none
module kgc_host_model
    import kgc_pkg::*;
(
    input wire logic clock_i,
    input wire logic ack_i,
    input wire logic [KGC_DW-1:0] read_data_i,
    output logic csr_select_o,
    output logic data_reg_select_o,
    output logic bcc_select_o,
    output logic write_low_strobe_o,
    output logic [KGC_DW-1:0] bus_data_o,
    output logic timed_out_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        csr_select_o = 1'b0;
        data_reg_select_o = 1'b0;
        bcc_select_o = 1'b0;
        write_low_strobe_o = 1'b0;
        bus_data_o = 16'h0000;
        timed_out_o = 1'b0;
    end

    // one bus cycle: s picks csr, data or bcc; w high writes; held until ack seen or 20 clocks pass
    task automatic rw(input logic [1:0] s, input logic w, input logic [KGC_DW-1:0] d,
            output logic [KGC_DW-1:0] q);
        int k;
        @(posedge clock_i);
        csr_select_o <= (s == 2'h0);
        data_reg_select_o <= (s == 2'h1);
        bcc_select_o <= (s == 2'h2);
        write_low_strobe_o <= w;
        bus_data_o <= d; // two characters in line order, first in low byte
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (ack_i !== 1'b1 && k < 20);
        q = read_data_i;
        if (k >= 20) timed_out_o <= 1'b1;
        csr_select_o <= 1'b0;
        data_reg_select_o <= 1'b0;
        bcc_select_o <= 1'b0;
        write_low_strobe_o <= 1'b0;
        bus_data_o <= ~d;
        repeat (4) @(posedge clock_i);
    endtask : rw
endmodule : kgc_host_model
`default_nettype wire

// [kgc_pkg.sv]
`default_nettype none
package kgc_pkg;
    localparam int KGC_DW = 16;
    localparam int KGC_CNT_W = 5;

    // control and status field positions
    localparam int CSR_MODE_LSB = 0;
    localparam int CSR_MODE_MSB = 2;
    localparam int CSR_DDB = 3;
    localparam int CSR_CLR = 4;
    localparam int CSR_STEP = 5;
    localparam int CSR_SEN = 6;
    localparam int CSR_DONE = 7;
    localparam int CSR_QUO = 8;

    // polynomial_select codes
    localparam logic [2:0] MODE_CRC12 = 3'h0;
    localparam logic [2:0] MODE_CRC16 = 3'h1;
    localparam logic [2:0] MODE_LRC8 = 3'h2;
    localparam logic [2:0] MODE_LRC16 = 3'h3;
    localparam logic [2:0] MODE_CCITT = 3'h5;
    localparam logic [2:0] MODE_RESET = 3'h0;

    // right-shifting feedback masks
    localparam logic [15:0] POLY_CRC12 = 16'h0f01;
    localparam logic [15:0] POLY_CRC16 = 16'ha001;
    localparam logic [15:0] POLY_CCITT = 16'h8408;

    // shifts per load
    localparam logic [KGC_CNT_W-1:0] SHIFTS_ONE_CHAR = 5'h08;
    localparam logic [KGC_CNT_W-1:0] SHIFTS_TWO_CHAR = 5'h10;
    localparam logic [KGC_CNT_W-1:0] CNT_LAST = 5'h01;
    localparam logic [KGC_CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [KGC_DW-1:0] WORD_ZERO = 16'h0000;

    typedef enum logic [0:0] {
        KGC_IDLE = 1'b0,
        KGC_SHIFT = 1'b1
    } kgc_state_e;

    // one shift of the accumulation with quotient q
    function automatic logic [KGC_DW-1:0] kgc_bcc_step(input logic [2:0] mode,
            input logic [KGC_DW-1:0] bcc, input logic q);
        logic [KGC_DW-1:0] sr;
        sr = bcc >> 1;
        case (mode)
            MODE_CRC12: kgc_bcc_step = sr ^ ({KGC_DW{q}} & POLY_CRC12);
            MODE_CRC16: kgc_bcc_step = sr ^ ({KGC_DW{q}} & POLY_CRC16);
            MODE_CCITT: kgc_bcc_step = sr ^ ({KGC_DW{q}} & POLY_CCITT);
            MODE_LRC8: kgc_bcc_step = {8'h00, q, bcc[7:1]};
            MODE_LRC16: kgc_bcc_step = {q, bcc[15:1]};
            default: kgc_bcc_step = sr;
        endcase
    endfunction : kgc_bcc_step
endpackage : kgc_pkg
`default_nettype wire
